/* File: rtl/atc_top.sv */
// The Wishbone register port and the register offsets were decided locally.
`timescale 1ns/1ps
`include "atc_consts.svh"
module atc_top (
	input wire logic CLK_I,
	input wire logic RESET_N_I,
	input wire logic CYC_I,
	input wire logic STB_I,
	input wire logic WE_I,
	input wire logic [7:0] ADR_I,
	input wire logic [3:0] SEL_I,
	input wire logic [31:0] DAT_I,
	output logic [31:0] DAT_O,
	output logic ACK_O,
	input wire atc_pkg::atc_res_s RES_I,
	input wire logic SEQ_END_I,
	output logic CONV_ON_O,
	output logic THR_EVENT_O
);
	import atc_pkg::*;

	// one-hot of a buffer index
	function automatic atc_word_t onehot(input atc_idx_t idx);
		atc_word_t v;
		v = '0;
		v[idx] = 1'b1;
		return v;
	endfunction : onehot

	// merge a write into a 16-bit register by byte lanes
	function automatic atc_word_t merge16(input atc_word_t old, input atc_word_t nw,
		input logic [1:0] sel);
		atc_word_t v;
		v = old;
		if (sel[0]) begin
			v[7:0] = nw[7:0];
		end
		if (sel[1]) begin
			v[15:8] = nw[15:8];
		end
		return v;
	endfunction : merge16

	// control and status state
	atc_sel_t kind_r;
	atc_sel_t kind_nxt;
	atc_sel_t disp_r;
	atc_sel_t disp_nxt;
	atc_sel_t irq_r;
	atc_sel_t irq_nxt;
	logic en_r;
	logic en_nxt;
	logic on_r;
	logic on_nxt;
	atc_word_t hits_r;
	atc_word_t hits_nxt;
	logic seq_hit_r;
	logic seq_hit_nxt;
	logic evt_r;
	logic evt_nxt;
	logic ack_r;
	logic ack_nxt;
	logic [31:0] dat_r;
	logic [31:0] dat_nxt;

	// bus decode
	logic bus_req;
	logic bus_take;
	logic bus_wr_go;
	logic sel_ctrl;
	logic sel_conv;
	logic sel_hits;
	logic sel_buf;
	atc_word_t lane_mask;
	atc_word_t rd_ctrl;
	atc_word_t ctrl_new;
	logic ctrl_wr;
	logic conv_wr;
	logic [31:0] rd_word;

	// conversion path
	logic conv_go;
	atc_idx_t conv_chan;
	atc_idx_t mirr_idx;
	atc_word_t thr_lo;
	atc_word_t thr_hi;
	atc_word_t rd_bus;
	atc_dec_s dec;
	logic bus_buf_wr;
	logic buf_we;
	atc_idx_t buf_waddr;
	atc_word_t buf_wdata;
	atc_word_t set_mask;
	atc_word_t clr_mask;
	logic any_hit;
	logic seq_end_go;

	// wishbone request decode, one wait state per access
	assign bus_req = CYC_I & STB_I;
	assign bus_take = bus_req & ~ack_r;
	assign bus_wr_go = bus_req & ack_r & WE_I;
	assign sel_ctrl = ADR_I == `ATC_OFS_CTRL;
	assign sel_conv = ADR_I == `ATC_OFS_CONV;
	assign sel_hits = ADR_I == `ATC_OFS_HITS;
	assign sel_buf = (ADR_I[7:6] == `ATC_BUF_PAGE) & (ADR_I[1:0] == 2'h0);
	assign lane_mask = {{8{SEL_I[1]}}, {8{SEL_I[0]}}};

	// threshold_control_low image
	assign rd_ctrl = {6'h00, irq_r, en_r, 3'h0, disp_r, kind_r};
	assign ctrl_new = merge16(rd_ctrl, DAT_I[15:0], SEL_I[1:0]);
	assign ctrl_wr = bus_wr_go & sel_ctrl;
	assign conv_wr = bus_wr_go & sel_conv & SEL_I[0];

	// next values of the control fields
	assign kind_nxt = ctrl_wr ? ctrl_new[`ATC_KIND_MSB:`ATC_KIND_LSB] : kind_r;
	assign disp_nxt = ctrl_wr ? ctrl_new[`ATC_DISP_MSB:`ATC_DISP_LSB] : disp_r;
	assign en_nxt = ctrl_wr ? ctrl_new[`ATC_EN_BIT] : en_r;
	assign irq_nxt = ctrl_wr ? ctrl_new[`ATC_IRQ_MSB:`ATC_IRQ_LSB] : irq_r;
	assign on_nxt = conv_wr ? DAT_I[`ATC_CONV_ON_BIT] : on_r;

	// read mux; unmapped addresses read as zero
	assign rd_word = sel_ctrl ? {16'h0000, rd_ctrl} :
		sel_conv ? {31'h0, on_r} :
		sel_hits ? {16'h0000, hits_r} :
		sel_buf ? {16'h0000, rd_bus} :
		32'h0;
	assign ack_nxt = bus_take;
	assign dat_nxt = bus_take ? rd_word : dat_r;

	// conversions count only while the converter is switched on
	assign conv_go = RES_I.valid & on_r;
	assign conv_chan = RES_I.chan;
	assign mirr_idx = RES_I.chan + `ATC_HALF;

	atc_buf u_buf (
		.clk_i(CLK_I),
		.reset_n_i(RESET_N_I),
		.we_i(buf_we),
		.waddr_i(buf_waddr),
		.wdata_i(buf_wdata),
		.raddr_lo_i(conv_chan),
		.raddr_hi_i(mirr_idx),
		.raddr_bus_i(ADR_I[5:2]),
		.rdata_lo_o(thr_lo),
		.rdata_hi_o(thr_hi),
		.rdata_bus_o(rd_bus)
	);

	atc_cmp u_cmp (
		.kind_i(kind_r),
		.disp_i(disp_r),
		.enable_i(en_r),
		.value_i(RES_I.data),
		.lo_i(thr_lo),
		.hi_i(thr_hi),
		.dec_o(dec)
	);

	// buffer write port: conversions, or software while the converter is off
	assign bus_buf_wr = bus_wr_go & sel_buf & ~on_r;
	assign buf_we = (conv_go & (dec.wr_chan | dec.wr_mirr)) | bus_buf_wr;
	assign buf_waddr = conv_go ? (dec.wr_mirr ? mirr_idx : conv_chan) : ADR_I[5:2];
	assign buf_wdata = conv_go ? RES_I.data : merge16(rd_bus, DAT_I[15:0], SEL_I[1:0]);

	// sticky hit flags: set wins over a write-one-to-clear
	assign set_mask = conv_go ? ((dec.hit_chan ? onehot(conv_chan) : '0) |
		(dec.hit_mirr ? onehot(mirr_idx) : '0)) : '0;
	assign clr_mask = (bus_wr_go & sel_hits) ? (DAT_I[15:0] & lane_mask) : '0;
	assign hits_nxt = (hits_r & ~clr_mask) | set_mask;
	assign any_hit = |set_mask;

	// event pulse per selected mode; a hit in the ending cycle counts
	assign seq_end_go = SEQ_END_I & on_r & en_r;
	assign seq_hit_nxt = seq_end_go ? 1'b0 : (seq_hit_r | any_hit);
	assign evt_nxt = (irq_r == `ATC_IRQ_SEQ) ? seq_end_go :
		(irq_r == `ATC_IRQ_SEQHIT) ? (seq_end_go & (seq_hit_r | any_hit)) :
		(irq_r == `ATC_IRQ_MATCH) ? any_hit :
		1'b0;

	// reset image of threshold_control_low, split into its fields below
	localparam atc_word_t ctrl_rst = `ATC_CTRL_RST;

	// control fields
	always_ff @(posedge CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			kind_r <= ctrl_rst[`ATC_KIND_MSB:`ATC_KIND_LSB];
			disp_r <= ctrl_rst[`ATC_DISP_MSB:`ATC_DISP_LSB];
			en_r <= ctrl_rst[`ATC_EN_BIT];
			irq_r <= ctrl_rst[`ATC_IRQ_MSB:`ATC_IRQ_LSB];
			on_r <= 1'b0;
		end else begin
			kind_r <= kind_nxt;
			disp_r <= disp_nxt;
			en_r <= en_nxt;
			irq_r <= irq_nxt;
			on_r <= on_nxt;
		end
	end

	// status flags and event
	always_ff @(posedge CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			hits_r <= `ATC_HITS_RST;
			seq_hit_r <= 1'b0;
			evt_r <= 1'b0;
		end else begin
			hits_r <= hits_nxt;
			seq_hit_r <= seq_hit_nxt;
			evt_r <= evt_nxt;
		end
	end

	// bus answer registers
	always_ff @(posedge CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			ack_r <= 1'b0;
			dat_r <= 32'h0;
		end else begin
			ack_r <= ack_nxt;
			dat_r <= dat_nxt;
		end
	end

	assign ACK_O = ack_r;
	assign DAT_O = dat_r;
	assign CONV_ON_O = on_r;
	assign THR_EVENT_O = evt_r;

	// checks
	default clocking cb @(posedge CLK_I);
	endclocking
	default disable iff (!RESET_N_I);

	logic cmp_on;
	assign cmp_on = conv_go & en_r & (disp_r != `ATC_WD_LEGACY);
	logic evt_cause;
	assign evt_cause = any_hit | seq_end_go;

	// bus access: taken, acked one cycle later, ack drops after
	sequence s_take;
		bus_take;
	endsequence
	sequence s_answer;
		ACK_O ##1 !ACK_O;
	endsequence
	bus_ack_a: assert property (s_take |=> s_answer)
		else $error("bus ack not one cycle after request");

	unmapped_zero_a: assert property (bus_take && !sel_ctrl && !sel_conv && !sel_hits
		&& !sel_buf |=> DAT_O == 32'h0)
		else $error("unmapped read not zero");

	hit_sticky_a: assert property ((($past(hits_r) & ~hits_r) & ~$past(clr_mask)) == 16'h0)
		else $error("hit bit dropped without clear");

	greater_hit_a: assert property (cmp_on && kind_r == `ATC_CK_GREATER
		&& RES_I.data > thr_lo |=> hits_r[$past(conv_chan)])
		else $error("greater match did not set hit");

	less_hit_a: assert property (cmp_on && kind_r == `ATC_CK_LESS
		&& RES_I.data < thr_lo |=> hits_r[$past(conv_chan)])
		else $error("less match did not set hit");

	discard_keep_a: assert property (cmp_on && disp_r == `ATC_WD_DISCARD |-> !buf_we)
		else $error("discard mode wrote the buffer");

	inside_hit_a: assert property (cmp_on && kind_r == `ATC_CK_INSIDE |->
		dec.hit_chan == (RES_I.data > thr_lo && RES_I.data < thr_hi) && !dec.hit_mirr)
		else $error("inside window verdict wrong");

	inside_keep_a: assert property (cmp_on && kind_r == `ATC_CK_INSIDE
		&& disp_r == `ATC_WD_STORE && dec.hit_chan |-> buf_we && buf_waddr == conv_chan)
		else $error("inside store hit wrong slot");

	outside_mirr_a: assert property (cmp_on && kind_r == `ATC_CK_OUTSIDE |->
		dec.hit_mirr == (RES_I.data > thr_hi)
		&& dec.hit_chan == (RES_I.data > thr_hi || RES_I.data < thr_lo))
		else $error("outside window verdict wrong");

	upper_store_a: assert property (cmp_on && kind_r == `ATC_CK_OUTSIDE
		&& disp_r == `ATC_WD_STORE && RES_I.data > thr_hi |->
		buf_we && buf_waddr == mirr_idx && buf_wdata == RES_I.data)
		else $error("above upper not stored at mirror");

	lower_store_a: assert property (cmp_on && kind_r == `ATC_CK_OUTSIDE
		&& disp_r == `ATC_WD_STORE && RES_I.data < thr_lo && RES_I.data <= thr_hi
		|-> buf_we && buf_waddr == conv_chan)
		else $error("below lower not stored at channel");

	legacy_path_a: assert property (conv_go && !en_r |->
		buf_we && buf_waddr == conv_chan && set_mask == 16'h0)
		else $error("disabled detect did not store plainly");

	match_event_a: assert property (irq_r == `ATC_IRQ_MATCH && any_hit
		##1 irq_r == `ATC_IRQ_MATCH |-> THR_EVENT_O)
		else $error("immediate event missing");

	none_event_a: assert property ($past(irq_r) == `ATC_IRQ_NONE |-> !THR_EVENT_O)
		else $error("event raised in no-event mode");

	// a control write lands at the edge that samples its ack
	sequence s_irq_write;
		ctrl_wr && SEL_I[1];
	endsequence
	sequence s_irq_landed;
		irq_r == $past(DAT_I[`ATC_IRQ_MSB:`ATC_IRQ_LSB]);
	endsequence
	irq_write_a: assert property (s_irq_write |=> s_irq_landed)
		else $error("event select write lost");

	// scan-end events
	seq_event_a: assert property (irq_r == `ATC_IRQ_SEQ && seq_end_go |=> THR_EVENT_O)
		else $error("scan end event missing");

	seqhit_fire_a: assert property (irq_r == `ATC_IRQ_SEQHIT && seq_end_go
		&& (seq_hit_r || any_hit) |=> THR_EVENT_O)
		else $error("scan end event after a match missing");

	// an event only follows a match or a scan end
	event_cause_a: assert property (THR_EVENT_O |-> $past(evt_cause))
		else $error("event without a cause");

	// a mirrored hit lands in the mirrored flag
	mirr_flag_a: assert property (conv_go && dec.hit_mirr |=> hits_r[$past(mirr_idx)])
		else $error("mirrored hit flag not set");

	// mirror sits half the buffer away, wrapping for upper channels
	mirr_pair_a: assert property (RES_I.valid |-> mirr_idx == {~RES_I.chan[3], RES_I.chan[2:0]})
		else $error("mirror index wrong");

	// a plain store with a match writes the own slot with the result
	simple_store_a: assert property (cmp_on && kind_r[1] == 1'b0
		&& disp_r == `ATC_WD_STORE && dec.hit_chan |->
		buf_we && buf_waddr == conv_chan && buf_wdata == RES_I.data)
		else $error("simple store missed its slot");

	// software cannot reach the buffer while the converter runs
	buf_locked_a: assert property (bus_wr_go && sel_buf && on_r |->
		!buf_we || (conv_go && buf_wdata == RES_I.data))
		else $error("buffer written by software while on");

	// a write-one-to-clear with no competing hit empties those flags
	clear_works_a: assert property (bus_wr_go && sel_hits && set_mask == 16'h0 |=>
		(hits_r & $past(clr_mask)) == 16'h0)
		else $error("hit flags not cleared");

	// no answer without a request
	ack_idle_a: assert property (!bus_req |=> !ACK_O)
		else $error("ack without request");
endmodule : atc_top

/* File: pkg/atc_consts.svh */
`ifndef ATC_CONSTS_SVH
`define ATC_CONSTS_SVH

// buffer geometry
`define ATC_DW 16
`define ATC_DEPTH 16
`define ATC_HALF 4'h8

// register byte offsets
`define ATC_OFS_CTRL 8'h00
`define ATC_OFS_CONV 8'h04
`define ATC_OFS_HITS 8'h08
`define ATC_BUF_PAGE 2'h1

// threshold_control_low fields, and the converter-on bit of the register at ATC_OFS_CONV
`define ATC_KIND_LSB 0
`define ATC_KIND_MSB 1
`define ATC_DISP_LSB 2
`define ATC_DISP_MSB 3
`define ATC_EN_BIT 7
`define ATC_IRQ_LSB 8
`define ATC_IRQ_MSB 9
`define ATC_CONV_ON_BIT 0

// reset values
`define ATC_CTRL_RST 16'h0000
`define ATC_HITS_RST 16'h0000

// compare kinds
`define ATC_CK_LESS 2'h0
`define ATC_CK_GREATER 2'h1
`define ATC_CK_INSIDE 2'h2
`define ATC_CK_OUTSIDE 2'h3

// result dispositions
`define ATC_WD_STORE 2'h1
`define ATC_WD_DISCARD 2'h2
`define ATC_WD_LEGACY 2'h3

// event selects
`define ATC_IRQ_SEQ 2'h0
`define ATC_IRQ_SEQHIT 2'h1
`define ATC_IRQ_MATCH 2'h2
`define ATC_IRQ_NONE 2'h3

`endif

/* File: pkg/atc_pkg.sv */
`include "atc_consts.svh"
package atc_pkg;
	typedef logic [`ATC_DW-1:0] atc_word_t;
	typedef logic [3:0] atc_idx_t;
	typedef logic [1:0] atc_sel_t;

	// one finished conversion from the core
	typedef struct packed {
		logic valid;
		atc_idx_t chan;
		atc_word_t data;
	} atc_res_s;

	// comparison verdict for one conversion
	typedef struct packed {
		logic hit_chan;
		logic hit_mirr;
		logic wr_chan;
		logic wr_mirr;
	} atc_dec_s;
endpackage : atc_pkg

/* File: rtl/atc_cmp.sv */
`timescale 1ns/1ps
`include "atc_consts.svh"
module atc_cmp (
	input wire atc_pkg::atc_sel_t kind_i,
	input wire atc_pkg::atc_sel_t disp_i,
	input wire logic enable_i,
	input wire atc_pkg::atc_word_t value_i,
	input wire atc_pkg::atc_word_t lo_i,
	input wire atc_pkg::atc_word_t hi_i,
	output atc_pkg::atc_dec_s dec_o
);
	import atc_pkg::*;

	// raw relations, all unsigned and strict
	logic above_lo;
	logic below_lo;
	logic above_hi;
	logic below_hi;
	logic active;
	logic store;
	logic cond;
	assign above_lo = value_i > lo_i;
	assign below_lo = value_i < lo_i;
	assign above_hi = value_i > hi_i;
	assign below_hi = value_i < hi_i;
	assign active = enable_i & (disp_i != `ATC_WD_LEGACY);
	assign store = disp_i == `ATC_WD_STORE;

	// condition per compare kind
	assign cond = (kind_i == `ATC_CK_GREATER) ? above_lo :
		(kind_i == `ATC_CK_LESS) ? below_lo :
		(kind_i == `ATC_CK_INSIDE) ? (above_lo & below_hi) :
		(above_hi | below_lo);

	// hits and write targets; legacy path stores into the channel slot
	assign dec_o.hit_chan = active & cond;
	assign dec_o.hit_mirr = active & (kind_i == `ATC_CK_OUTSIDE) & above_hi;
	assign dec_o.wr_mirr = active & store & (kind_i == `ATC_CK_OUTSIDE) & above_hi;
	assign dec_o.wr_chan = active ? (store & cond & ~dec_o.wr_mirr) : 1'b1;
endmodule : atc_cmp

/* File: rtl/atc_buf.sv */
`timescale 1ns/1ps
`include "atc_consts.svh"
module atc_buf (
	input wire logic clk_i,
	input wire logic reset_n_i,
	input wire logic we_i,
	input wire atc_pkg::atc_idx_t waddr_i,
	input wire atc_pkg::atc_word_t wdata_i,
	input wire atc_pkg::atc_idx_t raddr_lo_i,
	input wire atc_pkg::atc_idx_t raddr_hi_i,
	input wire atc_pkg::atc_idx_t raddr_bus_i,
	output atc_pkg::atc_word_t rdata_lo_o,
	output atc_pkg::atc_word_t rdata_hi_o,
	output atc_pkg::atc_word_t rdata_bus_o
);
	import atc_pkg::*;

	atc_word_t mem_r [`ATC_DEPTH];

	// three read views: own slot, mirrored slot, bus
	assign rdata_lo_o = mem_r[raddr_lo_i];
	assign rdata_hi_o = mem_r[raddr_hi_i];
	assign rdata_bus_o = mem_r[raddr_bus_i];

	// single write port, cleared at reset
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			for (int i = 0; i < `ATC_DEPTH; i++) begin
				mem_r[i] <= '0;
			end
		end else if (we_i) begin
			mem_r[waddr_i] <= wdata_i;
		end
	end
endmodule : atc_buf

/* File: verif/atc_core_model.sv */
`timescale 1ns/1ps
module atc_core_model (
	input wire logic clk_i,
	input wire logic reset_n_i,
	input wire logic conv_on_i,
	output atc_pkg::atc_res_s res_o,
	output logic seq_end_o
);
	import atc_pkg::*;
	typedef struct packed {logic last; atc_idx_t chan; atc_word_t data;} atc_job_s;
	atc_job_s job_q[$];
	atc_job_s job;
	int gap = 0;
	int idle_n = 0;

	// queue one conversion; last marks the end of the scan
	task push(input atc_idx_t c, input atc_word_t v, input logic last);
		job_q.push_back({last, c, v});
	endtask : push

	// at most one result a cycle, none while the converter is off
	always @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			res_o <= '0;
			seq_end_o <= 1'b0;
		end else if (conv_on_i && job_q.size() != 0 && idle_n >= gap) begin
			job = job_q.pop_front();
			res_o <= {1'b1, job.chan, job.data};
			seq_end_o <= job.last;
			idle_n = 0;
		end else begin
			res_o <= {1'b0, ~res_o.chan, ~res_o.data}; // stale lines toggle
			seq_end_o <= 1'b0;
			idle_n++;
		end
	end
endmodule : atc_core_model

/* File: verif/tb.sv */
`timescale 1ns/1ps
`include "atc_consts.svh"
module tb;
	import atc_pkg::*;
	typedef struct {string nm; logic [31:0] v;} atc_exp_s;
	logic CLK_I = 1'b0;
	logic RESET_N_I = 1'b0;
	logic CYC_I = 1'b0;
	logic STB_I = 1'b0;
	logic WE_I = 1'b0;
	logic [7:0] ADR_I = '0;
	logic [3:0] SEL_I = '0;
	logic [31:0] DAT_I = '0;
	logic [31:0] DAT_O;
	logic ACK_O, SEQ_END_I, CONV_ON_O, THR_EVENT_O;
	atc_res_s RES_I;
	atc_exp_s exp_q[$];
	atc_exp_s e;
	atc_word_t ref_buf[16];
	atc_word_t lo, v;
	logic [15:0] ref_hits;
	logic [1:0] k, w, irq;
	logic en, scan_hit;
	logic [31:0] rnd = 32'h6e4ac6a1;
	logic [3:0] sel_v = 4'hf;
	int n_mismatch = 0;
	int num_checks = 0;
	int ev_n = 0;
	int ev_base, ev_exp, cyc_n = 0;

	always #5 CLK_I = ~CLK_I;

	atc_top dut (.CLK_I(CLK_I), .RESET_N_I(RESET_N_I), .CYC_I(CYC_I), .STB_I(STB_I),
		.WE_I(WE_I), .ADR_I(ADR_I), .SEL_I(SEL_I), .DAT_I(DAT_I), .DAT_O(DAT_O),
		.ACK_O(ACK_O), .RES_I(RES_I), .SEQ_END_I(SEQ_END_I), .CONV_ON_O(CONV_ON_O),
		.THR_EVENT_O(THR_EVENT_O));
	atc_core_model core (.clk_i(CLK_I), .reset_n_i(RESET_N_I), .conv_on_i(CONV_ON_O),
		.res_o(RES_I), .seq_end_o(SEQ_END_I));

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr

	function automatic logic [7:0] ba(input atc_idx_t n);
		return {`ATC_BUF_PAGE, n, 2'h0};
	endfunction : ba

	task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check

	task end_of_test;
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : end_of_test

	// one classic cycle, held until ack is sampled high
	task bus(input logic we, input logic [7:0] a, input logic [15:0] d);
		@(posedge CLK_I);
		CYC_I <= 1'b1;
		STB_I <= 1'b1;
		WE_I <= we;
		ADR_I <= a;
		DAT_I <= {16'h0, d};
		SEL_I <= sel_v;
		@(posedge CLK_I);
		while (ACK_O !== 1'b1) @(posedge CLK_I);
		CYC_I <= 1'b0;
		STB_I <= 1'b0;
	endtask : bus

	task rd(input logic [7:0] a, input logic [15:0] x, input string nm);
		exp_q.push_back('{nm, {16'h0, x}});
		bus(1'b0, a, 16'h0);
	endtask : rd

	// reference update, then hand the conversion to the core
	task conv(input atc_idx_t c, input atc_word_t val, input logic last);
		atc_idx_t m;
		atc_word_t l, h;
		logic ab, hc;
		m = c + `ATC_HALF;
		l = ref_buf[c];
		h = ref_buf[m];
		ab = (k == `ATC_CK_OUTSIDE) && (val > h);
		case (k)
			`ATC_CK_LESS: hc = val < l;
			`ATC_CK_GREATER: hc = val > l;
			`ATC_CK_INSIDE: hc = val > l && val < h;
			default: hc = ab || val < l;
		endcase
		if (!en || w == `ATC_WD_LEGACY) begin
			hc = 1'b0;
			ref_buf[c] = val;
		end
		if (hc) ref_hits[c] = 1'b1;
		if (hc && ab) ref_hits[m] = 1'b1;
		if (hc && w == `ATC_WD_STORE && ab) ref_buf[m] = val;
		if (hc && w == `ATC_WD_STORE && !ab) ref_buf[c] = val;
		if (hc && irq == `ATC_IRQ_MATCH) ev_exp++;
		scan_hit = scan_hit | hc;
		if (last && en && (irq == `ATC_IRQ_SEQ || (irq == `ATC_IRQ_SEQHIT && scan_hit)))
			ev_exp++;
		core.push(c, val, last);
	endtask : conv

	// read monitor, event counter and timeout
	always @(posedge CLK_I) begin
		if (ACK_O === 1'b1 && CYC_I && !WE_I && exp_q.size() != 0) begin
			e = exp_q.pop_front();
			check(e.nm, DAT_O, e.v);
		end
		if (THR_EVENT_O === 1'b1) ev_n++;
		cyc_n++;
		if (cyc_n == 8000) begin
			n_mismatch++;
			end_of_test();
		end
	end

	initial begin
		repeat (12) @(posedge CLK_I);
		RESET_N_I <= 1'b1;
		rd(`ATC_OFS_CTRL, `ATC_CTRL_RST, "ctrl");
		rd(`ATC_OFS_HITS, `ATC_HITS_RST, "hits");
		rd(`ATC_OFS_CONV, 16'h0, "conv");
		rd(ba(2), 16'h0, "slot2");
		bus(1'b1, 8'hfc, 16'h1234);
		rd(8'hfc, 16'h0, "unmapped");
		// only the upper byte lane is written
		sel_v = 4'h2;
		bus(1'b1, ba(3), 16'habcd);
		sel_v = 4'hf;
		rd(ba(3), 16'hab00, "lane1");
		for (int n = 0; n < 12; n++) begin
			k = n[1:0];
			irq = n[1:0];
			w = (n < 4) ? `ATC_WD_STORE : (n < 8) ? `ATC_WD_DISCARD :
				(n < 10) ? `ATC_WD_LEGACY : 2'h0;
			en = (n != 9);
			core.gap = (n % 2) * 3;
			rnd = lfsr(rnd);
			lo = {4'h3, rnd[11:0]};
			bus(1'b1, `ATC_OFS_CONV, 16'h0);
			bus(1'b1, ba(2), lo);
			bus(1'b1, ba(10), lo + 16'h2000);
			ref_buf[2] = lo;
			ref_buf[10] = lo + 16'h2000;
			bus(1'b1, `ATC_OFS_HITS, 16'hffff);
			ref_hits = '0;
			scan_hit = 1'b0;
			ev_exp = 0;
			ev_base = ev_n;
			bus(1'b1, `ATC_OFS_CTRL, {6'h0, irq, en, 3'h0, w, k});
			rd(`ATC_OFS_CTRL, {6'h0, irq, en, 3'h0, w, k}, "ctrl");
			bus(1'b1, `ATC_OFS_CONV, 16'h1);
			rd(`ATC_OFS_CONV, 16'h1, "conv");
			check("conv_on", {31'h0, CONV_ON_O}, 32'h1);
			bus(1'b1, ba(2), 16'hdead);
			rd(`ATC_OFS_HITS, 16'h0, "hits");
			for (int i = 0; i < 8; i++) begin
				rnd = lfsr(rnd);
				v = (i < 3) ? lo - 16'h1 + 16'(i) : (i < 6) ? lo + 16'h1ffc + 16'(i) : rnd[15:0];
				conv((i == 7) ? 4'ha : 4'h2, v, i == 7);
				if (i[0]) begin
					while (core.job_q.size() != 0) @(posedge CLK_I);
					repeat (3) @(posedge CLK_I);
					rd(`ATC_OFS_HITS, ref_hits, "hits");
					rd(ba(2), ref_buf[2], "slot2");
					rd(ba(10), ref_buf[10], "slot10");
					if (i[1]) begin
						bus(1'b1, `ATC_OFS_HITS, 16'hffff);
						ref_hits = '0;
					end
				end
			end
			check("events", ev_n - ev_base, ev_exp);
			$display("test %0d done", n);
		end
		// reset in mid-run: registers and buffer return to their reset values
		RESET_N_I <= 1'b0;
		repeat (3) @(posedge CLK_I);
		RESET_N_I <= 1'b1;
		rd(`ATC_OFS_CTRL, `ATC_CTRL_RST, "ctrl");
		rd(`ATC_OFS_CONV, 16'h0, "conv");
		rd(ba(2), 16'h0, "slot2");
		check("conv_on", {31'h0, CONV_ON_O}, 32'h0);
		$display("reset test done");
		end_of_test();
	end
endmodule : tb
